// >>> bench/hbdma_chk_sva.sv
`timescale 1ns/100ps
// Port-level timing checks of the transfer controller
module hbdma_chk_sva (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        srst_i,
  // Register port
  input wire logic [7:0]  reg_code_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  // Interrupt
  input wire logic [15:0] processor_irq_mask_i,
  input wire logic        master_irq_enable_i,
  input wire logic        irq_o,
  // Transfer
  input wire logic        dma_request_out_o,
  input wire logic        end_of_transfer_i,
  input wire logic        list_buffer_select_o,
  input wire logic        transfer_direction_o,
  input wire logic        transfer_active_o,
  input wire logic        buffer_fill_update_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // Request needs the run bit, and rests between bursts
  property p_req_run; dma_request_out_o |-> $past(transfer_active_o); endproperty
  a_req_run: assert property (p_req_run) else $error("request without run");
  property p_gap; $fell(dma_request_out_o) |=> !dma_request_out_o; endproperty
  a_gap: assert property (p_gap) else $error("burst gap short");
  // End of transfer clears the run bit
  property p_eot; end_of_transfer_i |=> !transfer_active_o ##1 !dma_request_out_o; endproperty
  a_eot: assert property (p_eot) else $error("external end ignored");
  property p_end; buffer_fill_update_o |-> !transfer_active_o ##1 !buffer_fill_update_o; endproperty
  a_end: assert property (p_end) else $error("internal end wrong");
  // Steering bits follow the setup write
  property p_steer; reg_wr_i && reg_code_i == hbdma_pkg::SETUP_WR_CODE |=>
    list_buffer_select_o == $past(reg_wdata_i[1]) && transfer_direction_o == $past(reg_wdata_i[0]);
  endproperty
  a_steer: assert property (p_steer) else $error("steering wrong");
  // Interrupt gating and read data hold
  property p_irq_en; !master_irq_enable_i |=> !irq_o; endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq without master");
  property p_irq_mask; processor_irq_mask_i == 16'h0000 |=> !irq_o; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq without mask");
  property p_rd_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule
bind hbdma_transfer_ctrl hbdma_chk_sva u_chk (
  .clock_i, .srst_i, .reg_code_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
  .processor_irq_mask_i, .master_irq_enable_i, .irq_o, .dma_request_out_o,
  .end_of_transfer_i, .list_buffer_select_o, .transfer_direction_o,
  .transfer_active_o, .buffer_fill_update_o
);

// >>> bench/hbdma_host_model.sv
`timescale 1ns/100ps
// System DMA controller: one burst of acknowledges per raised request
module hbdma_host_model (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  // Handshake
  input  wire logic       req_i,
  input  wire logic [3:0] beats_i,
  input  wire logic       slow_i,
  output logic            ack_o,
  output int              acks_o
);
  logic [3:0] taken_q;
  logic       pace_q;
  // Acknowledge only while requested, never beyond the burst
  always @(posedge clock_i) begin
    if (srst_i) begin
      ack_o <= 1'b0;
      taken_q <= 4'h0;
      pace_q <= 1'b0;
      acks_o <= 0;
    end else begin
      pace_q <= ~pace_q;
      if (ack_o && req_i) acks_o <= acks_o + 1;
      taken_q <= req_i ? taken_q + 4'(ack_o) : 4'h0;
      ack_o <= req_i && (taken_q + 4'(ack_o)) < beats_i && (!slow_i || pace_q);
    end
  end
endmodule

// >>> bench/tb.sv
`timescale 1ns/100ps
// Register-level tests of the transfer controller
module tb;
  logic        clock_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [7:0]  code = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic        master = 1'b0;
  logic [15:0] mask = 16'h0004;
  logic        end_of_transfer = 1'b0;
  logic [3:0]  beats = 4'h1;
  logic        slow = 1'b0;
  logic [15:0] rdata;
  logic        irq, req, ack, list, dir, act, fill, req_q;
  int          acks, rises, errors, tests_run, a0, r0;
  logic [3:0]  bt [4] = '{hbdma_pkg::BEATS_ONE, hbdma_pkg::BEATS_FOUR,
                          hbdma_pkg::BEATS_EIGHT, hbdma_pkg::BEATS_ONE};
  always #50 clock_i = ~clock_i;
  hbdma_transfer_ctrl uut (.clock_i(clock_i), .srst_i(srst_i), .ce_i(1'b1), .reg_code_i(code),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdata),
    .processor_irq_mask_i(mask), .master_irq_enable_i(master),
    .other_irq_events_i(16'h0000), .irq_o(irq), .dma_request_out_o(req), .dma_ack_i(ack),
    .end_of_transfer_i(end_of_transfer), .pio_access_i(1'b0), .list_buffer_select_o(list),
    .transfer_direction_o(dir), .transfer_active_o(act), .buffer_fill_update_o(fill));
  hbdma_host_model u_host (.clock_i(clock_i), .srst_i(srst_i), .req_i(req), .beats_i(beats),
    .slow_i(slow), .ack_o(ack), .acks_o(acks));
  // Count raised requests
  always @(posedge clock_i) begin
    req_q <= req;
    if (req && !req_q) rises <= rises + 1;
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] c, input logic [15:0] d);
    @(posedge clock_i);
    code <= c;
    wd <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task automatic rdchk(input string n, input logic [7:0] c, input logic [15:0] e);
    @(posedge clock_i);
    code <= c;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    @(negedge clock_i);
    chk(n, rdata, e);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (6000) @(posedge clock_i);
    errors++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clock_i);
    srst_i <= 1'b0;
    rdchk("setup", hbdma_pkg::SETUP_RD_CODE, 16'h0000);
    rdchk("count", hbdma_pkg::COUNT_RD_CODE, 16'h0000);
    rdchk("status", hbdma_pkg::STATUS_RD_CODE, 16'h0000);
    rdchk("unmapped", 8'h30, 16'h0000);
    wr_reg(hbdma_pkg::COUNT_WR_CODE, 16'h1234);
    rdchk("count", hbdma_pkg::COUNT_RD_CODE, 16'h1234);
    wr_reg(hbdma_pkg::SETUP_WR_CODE, 16'hff8b);
    rdchk("setup", hbdma_pkg::SETUP_RD_CODE, 16'h0003);
    chk("steer", {14'h0, list, dir}, 16'h0003);
    $display("test registers done");
    wr_reg(hbdma_pkg::COUNT_WR_CODE, 16'h0000);
    wr_reg(hbdma_pkg::SETUP_WR_CODE, 16'h0014);
    repeat (10) @(negedge clock_i);
    chk("no request", 16'(req), 16'h0000);
    wr_reg(hbdma_pkg::SETUP_WR_CODE, 16'h0000);
    $display("test zero count done");
    // Each burst code, two bursts per transfer
    for (int k = 0; k < 4; k++) begin
      beats = bt[k];
      slow = k[0];
      master = (k != 1);
      mask = (k == 2) ? 16'h0000 : 16'h0004;
      a0 = acks;
      r0 = rises;
      wr_reg(hbdma_pkg::COUNT_WR_CODE, {10'h0, bt[k], 2'b00});
      wr_reg(hbdma_pkg::SETUP_WR_CODE, {9'h0, 2'(k), 5'h14});
      for (int n = 0; n < 400 && fill !== 1'b1; n++) @(negedge clock_i);
      chk("fill", 16'(fill), 16'h0001);
      chk("accesses", 16'(acks - a0), {11'h0, bt[k], 1'b0});
      chk("requests", 16'(rises - r0), 16'h0002);
      rdchk("setup", hbdma_pkg::SETUP_RD_CODE, {9'h0, 2'(k), 5'h04});
      rdchk("status", hbdma_pkg::STATUS_RD_CODE, 16'h0004);
      chk("irq", 16'(irq), 16'(master && mask[2]));
      wr_reg(hbdma_pkg::STATUS_WR_CODE, 16'h0004);
      rdchk("status", hbdma_pkg::STATUS_RD_CODE, 16'h0000);
      chk("irq", 16'(irq), 16'h0000);
      $display("test burst code %0d done", k);
    end
    master = 1'b1;
    mask = 16'h0004;
    a0 = acks;
    wr_reg(hbdma_pkg::SETUP_WR_CODE, 16'h0010);
    repeat (20) @(negedge clock_i);
    chk("running", 16'(acks > a0), 16'h0001);
    end_of_transfer <= 1'b1;
    @(posedge clock_i);
    end_of_transfer <= 1'b0;
    rdchk("setup", hbdma_pkg::SETUP_RD_CODE, 16'h0000);
    rdchk("status", hbdma_pkg::STATUS_RD_CODE, 16'h0004);
    wr_reg(hbdma_pkg::STATUS_WR_CODE, 16'hffff);
    $display("test external end done");
    wr_reg(hbdma_pkg::COUNT_WR_CODE, 16'h0100);
    wr_reg(hbdma_pkg::SETUP_WR_CODE, 16'h0014);
    repeat (10) @(posedge clock_i);
    wr_reg(hbdma_pkg::SETUP_WR_CODE, 16'h0000);
    repeat (3) @(negedge clock_i);
    a0 = acks;
    repeat (10) @(negedge clock_i);
    chk("stopped", 16'(acks - a0), 16'h0000);
    chk("request", 16'(req), 16'h0000);
    $display("test abort done");
    tally_and_finish();
  end
endmodule

// >>> src/hbdma_byte_counter.sv
`timescale 1ns/100ps
// Down counter of bytes still to move; saturates at zero
module hbdma_byte_counter #(
  parameter int WIDTH = 16
) (
  // Clock and control
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  // Load and count
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] load_val_i,
  input  wire logic             dec_i,
  input  wire logic [WIDTH-1:0] dec_val_i,
  // State
  output logic      [WIDTH-1:0] value_o,
  output logic                  zero_o
);

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  // Next count: load wins, decrement never wraps below zero
  always_comb begin
    cnt_d = cnt_q;
    if (load_i) begin
      cnt_d = load_val_i;
    end else if (dec_i) begin
      cnt_d = (cnt_q > dec_val_i) ? cnt_q - dec_val_i : '0;
    end
  end

  // Count register
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
    end
  end

  assign value_o = cnt_q;
  assign zero_o  = (cnt_q == '0);

endmodule

// >>> src/hbdma_pkg.sv
package hbdma_pkg;

  // Register command codes: read code, write code has bit 7 set
  localparam logic [7:0] SETUP_RD_CODE   = 8'h21;
  localparam logic [7:0] COUNT_RD_CODE   = 8'h22;
  localparam logic [7:0] STATUS_RD_CODE  = 8'h24;
  localparam logic [7:0] SETUP_WR_CODE   = 8'ha1;
  localparam logic [7:0] COUNT_WR_CODE   = 8'ha2;
  localparam logic [7:0] STATUS_WR_CODE  = 8'ha4;

  // Field positions in dma_setup; ALLDONE_BIT is the done bit in status
  localparam int DIR_BIT     = 0;
  localparam int LIST_BIT    = 1;
  localparam int USECNT_BIT  = 2;
  localparam int RUN_BIT     = 4;
  localparam int BURST_LO    = 5;
  localparam int ALLDONE_BIT = 2;

  // Writable bits of dma_setup; reserved bits read zero
  localparam logic [15:0] SETUP_WMASK  = 16'h0077;
  localparam logic [15:0] SETUP_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // Burst field codes and their access counts
  typedef enum logic [1:0] {
    BURST_ONE   = 2'b00,
    BURST_FOUR  = 2'b01,
    BURST_EIGHT = 2'b10,
    BURST_RSVD  = 2'b11
  } hbdma_burst_e;
  localparam logic [3:0] BEATS_ONE   = 4'h1;
  localparam logic [3:0] BEATS_FOUR  = 4'h4;
  localparam logic [3:0] BEATS_EIGHT = 4'h8;

  // Bytes moved per acknowledged access on the 16-bit data bus
  localparam logic [15:0] BYTES_PER_ACCESS = 16'h0002;

  // Largest legal counts, kept for software reference
  localparam logic [15:0] ACK_LIST_MAX = 16'h1000;
  localparam logic [15:0] ISO_LIST_MAX = 16'h0800;

endpackage

// >>> src/hbdma_sticky_flags.sv
`timescale 1ns/100ps
// Sticky event flags: set by hardware, cleared by writing ones, set wins
module hbdma_sticky_flags #(
  parameter int WIDTH = 16
) (
  // Clock and control
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  // Events and clears
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic [WIDTH-1:0] clr_i,
  // Flags
  output logic      [WIDTH-1:0] flags_o
);

  logic [WIDTH-1:0] flags_q;
  logic [WIDTH-1:0] flags_d;

  // Clear only written ones; a new event in the same cycle survives
  always_comb begin
    flags_d = (flags_q & ~clr_i) | set_i;
  end

  // Flag register, live straight from reset
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      flags_q <= '0;
    end else if (ce_i) begin
      flags_q <= flags_d;
    end
  end

  assign flags_o = flags_q;

endmodule

// >>> src/hbdma_transfer_ctrl.sv
`timescale 1ns/100ps
// Transfer setup, byte counting and request handshake for the list buffers
module hbdma_transfer_ctrl (
  // Clock, reset, enable
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  // Register port
  input  wire logic [7:0]  reg_code_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  // Interrupt gating and other status sources
  input  wire logic [15:0] processor_irq_mask_i,
  input  wire logic        master_irq_enable_i,
  input  wire logic [15:0] other_irq_events_i,
  output logic             irq_o,
  // DMA handshake
  output logic             dma_request_out_o,
  input  wire logic        dma_ack_i,
  input  wire logic        end_of_transfer_i,
  // Programmed-I/O accesses to the list buffers
  input  wire logic        pio_access_i,
  // Buffer steering
  output logic             list_buffer_select_o,
  output logic             transfer_direction_o,
  output logic             transfer_active_o,
  output logic             buffer_fill_update_o
);

  // Register state
  logic [15:0] dma_setup_q;
  logic [15:0] dma_setup_d;
  logic [15:0] byte_count_q;
  logic [15:0] byte_count_d;

  // Burst tracking and outputs
  logic [3:0]  beat_q;
  logic [3:0]  beat_d;
  logic        dma_request_out_q;
  logic        dma_request_out_d;
  logic        gap_q;
  logic        gap_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic        irq_q;
  logic        irq_d;
  logic        upd_q;
  logic        upd_d;

  // Decoded controls
  logic        run_bit;
  logic        use_cnt;
  logic [1:0]  burst_field;
  logic [3:0]  burst_beats;
  logic        setup_wr;
  logic        start_run;
  logic        ack_taken;
  logic        int_eot;
  logic        ext_eot;
  logic        done_evt;
  logic [15:0] remain;
  logic        remain_zero;
  logic        cnt_load;
  logic        cnt_dec;
  logic [15:0] status;
  logic [15:0] status_set;
  logic [15:0] status_clr;

  assign run_bit     = dma_setup_q[hbdma_pkg::RUN_BIT];
  assign use_cnt     = dma_setup_q[hbdma_pkg::USECNT_BIT];
  assign burst_field = dma_setup_q[hbdma_pkg::BURST_LO +: 2];
  assign setup_wr    = reg_wr_i && (reg_code_i == hbdma_pkg::SETUP_WR_CODE);
  assign start_run   = setup_wr && reg_wdata_i[hbdma_pkg::RUN_BIT] && !run_bit;

  // Burst length from the two-bit field; reserved code falls back to single
  always_comb begin
    case (burst_field)
      hbdma_pkg::BURST_ONE:   burst_beats = hbdma_pkg::BEATS_ONE;
      hbdma_pkg::BURST_FOUR:  burst_beats = hbdma_pkg::BEATS_FOUR;
      hbdma_pkg::BURST_EIGHT: burst_beats = hbdma_pkg::BEATS_EIGHT;
      default:                burst_beats = hbdma_pkg::BEATS_ONE;
    endcase
  end

  // Counter is loaded at start only when the counter bit is set
  assign cnt_load  = start_run && reg_wdata_i[hbdma_pkg::USECNT_BIT];
  assign ack_taken = dma_request_out_q && dma_ack_i && run_bit;
  assign cnt_dec   = ack_taken || pio_access_i;

  // Remaining byte count
  hbdma_byte_counter #(
    .WIDTH (16)
  ) u_byte_counter (
    .clock_i    (clock_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .load_i     (cnt_load),
    .load_val_i (byte_count_q),
    .dec_i      (cnt_dec),
    .dec_val_i  (hbdma_pkg::BYTES_PER_ACCESS),
    .value_o    (remain),
    .zero_o     (remain_zero)
  );

  // Internal end when the counted bytes run out; external end from the far party
  assign int_eot  = cnt_dec && !cnt_load && (remain <= hbdma_pkg::BYTES_PER_ACCESS)
                    && !remain_zero && (use_cnt || pio_access_i);
  assign ext_eot  = end_of_transfer_i;
  assign done_evt = int_eot || ext_eot;

  // Setup and count registers, with hardware clear of the run bit
  always_comb begin
    dma_setup_d  = dma_setup_q;
    byte_count_d = byte_count_q;
    if (setup_wr) begin
      dma_setup_d = reg_wdata_i & hbdma_pkg::SETUP_WMASK;
    end
    if (reg_wr_i && (reg_code_i == hbdma_pkg::COUNT_WR_CODE)) begin
      byte_count_d = reg_wdata_i;
    end
    if (run_bit && done_evt) begin
      dma_setup_d[hbdma_pkg::RUN_BIT] = 1'b0;
    end
  end

  // Request and burst pacing: drop for two cycles between bursts
  always_comb begin
    beat_d = beat_q;
    gap_d  = 1'b0;
    dma_request_out_d = 1'b0;
    if (!run_bit || done_evt || (setup_wr && !reg_wdata_i[hbdma_pkg::RUN_BIT])) begin
      beat_d = 4'h0;
    end else begin
      if (ack_taken) begin
        if (beat_q + 4'h1 >= burst_beats) begin
          beat_d = 4'h0;
          gap_d  = 1'b1;
        end else begin
          beat_d = beat_q + 4'h1;
        end
      end
      // Needs a non-zero loaded count when the counter is used
      dma_request_out_d = !gap_d && !gap_q && (!use_cnt || !remain_zero);
    end
  end

  // Status flags: done bit plus the other sources
  always_comb begin
    status_set              = other_irq_events_i;
    status_set[hbdma_pkg::ALLDONE_BIT] = done_evt;
    status_clr              = '0;
    if (reg_wr_i && (reg_code_i == hbdma_pkg::STATUS_WR_CODE)) begin
      status_clr = reg_wdata_i;
    end
  end

  hbdma_sticky_flags #(
    .WIDTH (16)
  ) u_status (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .ce_i    (ce_i),
    .set_i   (status_set),
    .clr_i   (status_clr),
    .flags_o (status)
  );

  // Read data, interrupt and buffer update pulse
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd_i) begin
      case (reg_code_i)
        hbdma_pkg::SETUP_RD_CODE:  rdata_d = dma_setup_q;
        hbdma_pkg::COUNT_RD_CODE:  rdata_d = byte_count_q;
        hbdma_pkg::STATUS_RD_CODE: rdata_d = status;
        default:                   rdata_d = 16'h0000;
      endcase
    end
    irq_d = master_irq_enable_i && |(status & processor_irq_mask_i);
    upd_d = int_eot;
  end

  // State registers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dma_setup_q  <= hbdma_pkg::SETUP_RESET;
      byte_count_q <= hbdma_pkg::COUNT_RESET;
      beat_q       <= 4'h0;
      gap_q        <= 1'b0;
      dma_request_out_q       <= 1'b0;
      rdata_q      <= 16'h0000;
      irq_q        <= 1'b0;
      upd_q        <= 1'b0;
    end else if (ce_i) begin
      dma_setup_q  <= dma_setup_d;
      byte_count_q <= byte_count_d;
      beat_q       <= beat_d;
      gap_q        <= gap_d;
      dma_request_out_q       <= dma_request_out_d;
      rdata_q      <= rdata_d;
      irq_q        <= irq_d;
      upd_q        <= upd_d;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata_o          = rdata_q;
  assign irq_o                = irq_q;
  assign dma_request_out_o    = dma_request_out_q;
  assign list_buffer_select_o = dma_setup_q[hbdma_pkg::LIST_BIT];
  assign transfer_direction_o = dma_setup_q[hbdma_pkg::DIR_BIT];
  assign transfer_active_o    = run_bit;
  assign buffer_fill_update_o = upd_q;

endmodule
